// >>> uepde_pkg.sv
// constants and types of the endpoint descriptor engine
// Summary of operation
// - writing toggle reset request loads data toggle from toggle preset value
// - setup token on endpoint zero forces both direction toggles to one
// - endpoint zero uses shared bit as preset, copied on toggle reset request
// - interrupt endpoint shared bit one: rate feedback, every packet sent with toggle zero
// - type bit zero means generic bulk/interrupt, one means isochronous
// - byte count is receive capacity for OUT, bytes to send for IN
// - each good packet subtracts its size from remaining byte count
// - short OUT packet clears armed bit, leaves unused space in count
// - address field holds buffer address bits 21 to 6, 64-byte aligned
// - each good packet adds packet size divided by 64 to offset
// - setup on endpoint zero uses address field plus setup buffer offset, ignores offset and count
// - setup stage longer than 8 bytes stores only first 8 bytes
// - armed bit clears on short OUT packet, count reaching zero, or skip write
// - data token to disabled endpoint is ignored, no data nor handshake; setup on endpoint zero is still stored
// - stall only when not armed and halt request set; armed wins
package uepde_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_COUNT   = 4'h1;
    localparam logic [3:0] ADDR_BUF     = 4'h2;
    localparam logic [3:0] ADDR_SETUP   = 4'h3;
    localparam logic [3:0] ADDR_STATUS  = 4'h4;
    localparam logic [3:0] ADDR_SKIP    = 4'h5;
    // ****************************************
    // control word fields
    // ****************************************
    localparam int CTRL_ARMED_BIT   = 0;
    localparam int CTRL_DIS_BIT     = 1;
    localparam int CTRL_HALT_BIT    = 2;
    localparam int CTRL_TRR_BIT     = 3;
    localparam int CTRL_FTP_BIT     = 4;
    localparam int CTRL_TYPE_BIT    = 5;
    localparam int CTRL_EPZ_BIT     = 6;
    localparam int CTRL_INTR_BIT    = 7;
    localparam int CTRL_IN_BIT      = 8;
    // ****************************************
    // sizes
    // ****************************************
    localparam int CNT_W            = 10;
    localparam int ADDR_FLD_W       = 16;
    localparam int OFS_W            = 16;
    localparam int MEM_ADDR_W       = 22;
    localparam int ALIGN_SHIFT      = 6;
    localparam int SETUP_MAX_BYTES  = 8;
    localparam logic [31:0] RESET_CTRL = 32'h0000_0002;
    // ****************************************
    // engine states
    // ****************************************
    typedef enum logic [1:0] {UEPDE_IDLE, UEPDE_DATA, UEPDE_SETUP} uepde_state_t;
endpackage : uepde_pkg

// >>> uepde_engine.sv
// endpoint descriptor engine: entry registers, toggle, count, offset, setup store
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module uepde_engine
    import uepde_pkg::*;
(
    // clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_b_in,
    // register port
    input  wire logic [3:0]             reg_addr_in,
    input  wire logic [31:0]            reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic [31:0]                 reg_rdata_out,
    // token and packet events from the serial engine
    input  wire logic                   tok_data_in,
    input  wire logic                   tok_setup_in,
    input  wire logic                   pkt_byte_valid_in,
    input  wire logic [7:0]             pkt_byte_in,
    input  wire logic                   pkt_good_in,
    input  wire logic [CNT_W-1:0]       pkt_size_in,
    input  wire logic                   pkt_short_in,
    // token answer
    output logic                        tok_ignore_out,
    output logic                        tok_stall_out,
    output logic                        tok_accept_out,
    output logic                        tx_toggle_out,
    // memory write port
    output logic                        mem_wr_out,
    output logic [MEM_ADDR_W-1:0]       mem_addr_out,
    output logic [7:0]                  mem_wdata_out
);
    import uepde_pkg::*;

    // ****************************************
    // entry state
    // ****************************************
    logic [31:0]            ctrl_reg;
    logic [CNT_W-1:0]       count_reg;
    logic [ADDR_FLD_W-1:0]  buf_addr_reg;
    logic [OFS_W-1:0]       offset_reg;
    logic [OFS_W-1:0]       setup_ofs_reg;
    logic                   tog_out_reg;
    logic                   tog_in_reg;
    logic [3:0]             setup_cnt_reg;
    logic [5:0]             byte_idx_reg;
    logic [31:0]            reg_rdata_reg;
    logic                   mem_wr_reg;
    logic [MEM_ADDR_W-1:0]  mem_addr_reg;
    logic [7:0]             mem_wdata_reg;
    uepde_state_t           state_reg;
    uepde_state_t           state_next;

    // ****************************************
    // decode
    // ****************************************
    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = reg_wr_in && (a == o);
    endfunction : hit

    wire logic wr_ctrl   = hit(reg_addr_in, ADDR_CTRL);
    wire logic wr_count  = hit(reg_addr_in, ADDR_COUNT);
    wire logic wr_buf    = hit(reg_addr_in, ADDR_BUF);
    wire logic wr_setup  = hit(reg_addr_in, ADDR_SETUP);
    wire logic wr_skip   = hit(reg_addr_in, ADDR_SKIP) && reg_wdata_in[0];
    wire logic armed     = ctrl_reg[CTRL_ARMED_BIT];
    wire logic disabled  = ctrl_reg[CTRL_DIS_BIT];
    wire logic halt      = ctrl_reg[CTRL_HALT_BIT];
    wire logic ftp       = ctrl_reg[CTRL_FTP_BIT];
    wire logic is_iso    = ctrl_reg[CTRL_TYPE_BIT];
    wire logic is_epz    = ctrl_reg[CTRL_EPZ_BIT];
    wire logic is_intr   = ctrl_reg[CTRL_INTR_BIT] && !is_iso;
    wire logic is_in     = ctrl_reg[CTRL_IN_BIT];
    // shared bit: preset on endpoint zero, rate feedback on interrupt
    wire logic rate_fb   = is_intr && !is_epz && ftp;
    wire logic trr_wr    = wr_ctrl && reg_wdata_in[CTRL_TRR_BIT];
    wire logic do_setup  = tok_setup_in && is_epz;
    wire logic do_data   = tok_data_in && !disabled;

    // ****************************************
    // token answer
    // ****************************************
    assign tok_ignore_out = tok_data_in && disabled;
    assign tok_stall_out  = do_data && !armed && halt;
    assign tok_accept_out = do_data && armed;
    assign tx_toggle_out  = rate_fb ? 1'b0 : tog_in_reg;

    // ****************************************
    // packet arithmetic
    // ****************************************
    wire logic             pkt_done  = pkt_good_in && (state_reg == UEPDE_DATA);
    wire logic [CNT_W-1:0] count_sub = count_reg - pkt_size_in;
    wire logic [OFS_W-1:0] ofs_add   = offset_reg
                                     + OFS_W'(pkt_size_in >> ALIGN_SHIFT);
    wire logic             cnt_zero  = (count_sub == '0) || (pkt_size_in > count_reg);
    // short packets only end the buffer on OUT
    wire logic             clr_armed = wr_skip
                                     || (pkt_done && (cnt_zero
                                     || (pkt_short_in && !is_in)));
    // address field lands at bits 21..6, offset scaled by 64
    wire logic [MEM_ADDR_W-1:0] data_base  = MEM_ADDR_W'({buf_addr_reg, 6'h00})
                                           + MEM_ADDR_W'({offset_reg, 6'h00});
    wire logic [MEM_ADDR_W-1:0] setup_base = MEM_ADDR_W'({buf_addr_reg, 6'h00})
                                           + MEM_ADDR_W'({setup_ofs_reg, 6'h00});
    wire logic setup_keep = (state_reg == UEPDE_SETUP) && pkt_byte_valid_in
                          && (setup_cnt_reg < 4'(SETUP_MAX_BYTES));
    wire logic data_keep  = (state_reg == UEPDE_DATA) && pkt_byte_valid_in && !is_in;

    // ****************************************
    // state machine
    // ****************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            UEPDE_IDLE: begin
                if (do_setup) begin
                    state_next = UEPDE_SETUP;
                end else if (tok_accept_out) begin
                    state_next = UEPDE_DATA;
                end
            end
            UEPDE_DATA: begin
                // a fresh token ends this stage and may open the next one
                if (do_setup) begin
                    state_next = UEPDE_SETUP;
                end else if (tok_accept_out) begin
                    state_next = UEPDE_DATA;
                end else if (pkt_good_in || tok_data_in || tok_setup_in) begin
                    state_next = UEPDE_IDLE;
                end
            end
            UEPDE_SETUP: begin
                if (do_setup) begin
                    state_next = UEPDE_SETUP;
                end else if (tok_accept_out) begin
                    state_next = UEPDE_DATA;
                end else if (pkt_good_in || tok_data_in || tok_setup_in) begin
                    state_next = UEPDE_IDLE;
                end
            end
            default: state_next = UEPDE_IDLE;
        endcase
    end

    // ****************************************
    // control word
    // ****************************************
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_reg <= RESET_CTRL;
        end else if (clr_armed) begin
            // hardware clear wins; software may not rewrite while armed anyway
            ctrl_reg <= ctrl_reg & ~(32'h1 << CTRL_ARMED_BIT);
        end else if (wr_ctrl) begin
            ctrl_reg <= reg_wdata_in & ~(32'h1 << CTRL_TRR_BIT);
        end
    end

    // ****************************************
    // data toggles
    // ****************************************
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tog_out_reg <= 1'b0;
            tog_in_reg  <= 1'b0;
        end else if (do_setup) begin
            tog_out_reg <= 1'b1;
            tog_in_reg  <= 1'b1;
        end else if (trr_wr) begin
            tog_out_reg <= reg_wdata_in[CTRL_FTP_BIT];
            tog_in_reg  <= reg_wdata_in[CTRL_FTP_BIT];
        end else if (pkt_done && !is_iso) begin
            if (is_in) begin
                tog_in_reg <= rate_fb ? 1'b0 : !tog_in_reg;
            end else begin
                tog_out_reg <= !tog_out_reg;
            end
        end
    end

    // ****************************************
    // count, address, offsets
    // ****************************************
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_reg     <= '0;
            buf_addr_reg  <= '0;
            offset_reg    <= '0;
            setup_ofs_reg <= '0;
        end else begin
            if (pkt_done) begin
                // underflow clamps to zero; leftover stays as unused space
                count_reg  <= cnt_zero ? '0 : count_sub;
                offset_reg <= ofs_add;
            end else if (wr_count) begin
                count_reg <= reg_wdata_in[CNT_W-1:0];
            end else if (wr_buf) begin
                offset_reg <= reg_wdata_in[31:16];
            end
            if (wr_buf) begin
                buf_addr_reg <= reg_wdata_in[ADDR_FLD_W-1:0];
            end
            if (wr_setup) begin
                setup_ofs_reg <= reg_wdata_in[OFS_W-1:0];
            end
        end
    end

    // ****************************************
    // byte store
    // ****************************************
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg     <= UEPDE_IDLE;
            setup_cnt_reg <= '0;
            byte_idx_reg  <= '0;
            mem_wr_reg    <= 1'b0;
            mem_addr_reg  <= '0;
            mem_wdata_reg <= '0;
        end else begin
            state_reg     <= state_next;
            mem_wr_reg    <= setup_keep || data_keep;
            mem_wdata_reg <= pkt_byte_in;
            if (setup_keep) begin
                mem_addr_reg  <= setup_base + MEM_ADDR_W'(setup_cnt_reg);
                setup_cnt_reg <= setup_cnt_reg + 4'h1;
            end else if (data_keep) begin
                mem_addr_reg  <= data_base + MEM_ADDR_W'(byte_idx_reg);
                byte_idx_reg  <= byte_idx_reg + 6'h01;
            end
            // a new token restarts byte numbering even without an idle cycle
            if (state_reg == UEPDE_IDLE || tok_data_in || tok_setup_in) begin
                setup_cnt_reg <= '0;
                byte_idx_reg  <= '0;
            end
        end
    end

    // ****************************************
    // register read
    // ****************************************
    wire logic [31:0] rd_mux =
        (reg_addr_in == ADDR_CTRL)   ? ctrl_reg :
        (reg_addr_in == ADDR_COUNT)  ? 32'(count_reg) :
        (reg_addr_in == ADDR_BUF)    ? {offset_reg, buf_addr_reg} :
        (reg_addr_in == ADDR_SETUP)  ? 32'(setup_ofs_reg) :
        (reg_addr_in == ADDR_STATUS) ? {28'h0000000, state_reg, tog_in_reg, tog_out_reg} :
        32'h0000_0000;

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_reg <= '0;
        end else begin
            reg_rdata_reg <= reg_rd_in ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata_out = reg_rdata_reg;
    assign mem_wr_out    = mem_wr_reg;
    assign mem_addr_out  = mem_addr_reg;
    assign mem_wdata_out = mem_wdata_reg;
endmodule : uepde_engine

// >>> uepde_engine_sva.sv
// checker for the endpoint descriptor engine ports
`timescale 1ns/100ps
module uepde_engine_sva
    import uepde_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_b_in,
    // token side
    input  wire logic                  tok_data_in,
    input  wire logic                  tok_setup_in,
    input  wire logic                  pkt_byte_valid_in,
    input  wire logic [7:0]            pkt_byte_in,
    input  wire logic                  tok_ignore_out,
    input  wire logic                  tok_stall_out,
    input  wire logic                  tok_accept_out,
    // memory side
    input  wire logic                  mem_wr_out,
    input  wire logic [MEM_ADDR_W-1:0] mem_addr_out,
    input  wire logic [7:0]            mem_wdata_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    // ****************************************
    // setup write counter
    // ****************************************
    // bit4 marks a setup stage; only setup writes are counted, so long OUT packets never wrap
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    assign cnt_next = tok_setup_in ? 5'h10 : (tok_data_in ? 5'h00 :
                      cnt_reg + {4'h0, mem_wr_out & cnt_reg[4]});
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_reg <= 5'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    sequence s_two_wr;
        mem_wr_out ##1 mem_wr_out;
    endsequence
    sequence s_first_setup_wr;
        cnt_reg[4] && (cnt_reg[3:0] == 4'h0) && mem_wr_out;
    endsequence
    AST_IGNORE_QUIET: assert property (tok_ignore_out |-> !tok_stall_out && !tok_accept_out)
        else $error("ignored token still answered");
    AST_STALL_ARMED: assert property (tok_stall_out |-> !tok_accept_out)
        else $error("stall and accept together");
    AST_ANSWER_CAUSE: assert property ((tok_stall_out || tok_accept_out) |-> tok_data_in)
        else $error("answer without token");
    AST_SETUP_CAP: assert property (cnt_reg[4] |-> cnt_reg[3:0] <= 4'h8)
        else $error("more than eight setup bytes stored");
    AST_MEMWR_LAT: assert property (mem_wr_out |-> $past(pkt_byte_valid_in))
        else $error("memory write without byte");
    AST_WDATA: assert property (mem_wr_out |-> mem_wdata_out == $past(pkt_byte_in))
        else $error("memory data differs from byte");
    AST_ADDR_STEP: assert property (s_two_wr |-> mem_addr_out == $past(mem_addr_out) + 22'h1)
        else $error("byte address did not step by one");
    AST_SETUP_ALIGN: assert property (s_first_setup_wr |-> mem_addr_out[5:0] == 6'h00)
        else $error("setup buffer not aligned");
endmodule : uepde_engine_sva

bind uepde_engine uepde_engine_sva sva_u (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .tok_data_in(tok_data_in),
    .tok_setup_in(tok_setup_in), .pkt_byte_valid_in(pkt_byte_valid_in),
    .pkt_byte_in(pkt_byte_in), .tok_ignore_out(tok_ignore_out),
    .tok_stall_out(tok_stall_out), .tok_accept_out(tok_accept_out),
    .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out)
);

// >>> uepde_host_model.sv
// host side model: tokens, packets, handshake answers
`timescale 1ns/100ps
module uepde_host_model
    import uepde_pkg::*;
(
    // clock
    input  wire logic             core_clk_in,
    // token and packet events
    output logic                  tok_data_out,
    output logic                  tok_setup_out,
    output logic                  byte_valid_out,
    output logic [7:0]            byte_out,
    output logic                  good_out,
    output logic [CNT_W-1:0]      size_out,
    output logic                  short_out,
    // answers: ignore, stall, accept, toggle
    input  wire logic [3:0]       answer_in
);
    initial begin
        {tok_data_out, tok_setup_out, byte_valid_out, good_out, short_out} = 5'h00;
        byte_out = 8'h00;
        size_out = 10'h000;
    end
    task automatic token(output logic [3:0] ans);
        @(posedge core_clk_in);
        tok_data_out <= 1'b1;
        #1 ans = answer_in;
        @(posedge core_clk_in);
        tok_data_out <= 1'b0;
    endtask : token
    // idle size and short lines show the inverse, not a stale value
    task automatic good(input logic [CNT_W-1:0] n, input logic s);
        @(posedge core_clk_in);
        good_out  <= 1'b1;
        size_out  <= n;
        short_out <= s;
        @(posedge core_clk_in);
        good_out  <= 1'b0;
        size_out  <= ~n;
        short_out <= ~s;
    endtask : good
    task automatic setup(input int n);
        @(posedge core_clk_in);
        tok_setup_out <= 1'b1;
        @(posedge core_clk_in);
        tok_setup_out <= 1'b0;
        for (int i = 0; i < n; i++) begin
            byte_valid_out <= 1'b1;
            byte_out       <= 8'hA0 + i[7:0];
            @(posedge core_clk_in);
        end
        byte_valid_out <= 1'b0;
        byte_out       <= 8'h5A;
    endtask : setup
endmodule : uepde_host_model

// >>> uepde_engine_tb.sv
// self-checking bench for the endpoint descriptor engine
`timescale 1ns/100ps
module uepde_engine_tb;
    import uepde_pkg::*;
    logic        core_clk_in, rst_b_in, reg_wr_in, reg_rd_in;
    logic [3:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out;
    logic        tok_data_in, tok_setup_in, pkt_byte_valid_in, pkt_good_in, pkt_short_in;
    logic [7:0]  pkt_byte_in, mem_wdata_out;
    logic [9:0]  pkt_size_in;
    logic        tok_ignore_out, tok_stall_out, tok_accept_out, tx_toggle_out, mem_wr_out;
    logic [21:0] mem_addr_out, first_addr;
    logic [3:0]  ans;
    int          n_fail = 0;
    int          n_tests = 0;
    int          n_wr = 0;
    uepde_engine dut_u (
        .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .tok_data_in(tok_data_in), .tok_setup_in(tok_setup_in),
        .pkt_byte_valid_in(pkt_byte_valid_in), .pkt_byte_in(pkt_byte_in),
        .pkt_good_in(pkt_good_in), .pkt_size_in(pkt_size_in), .pkt_short_in(pkt_short_in),
        .tok_ignore_out(tok_ignore_out), .tok_stall_out(tok_stall_out),
        .tok_accept_out(tok_accept_out), .tx_toggle_out(tx_toggle_out),
        .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out));
    uepde_host_model host_u (
        .core_clk_in(core_clk_in), .tok_data_out(tok_data_in), .tok_setup_out(tok_setup_in),
        .byte_valid_out(pkt_byte_valid_in), .byte_out(pkt_byte_in), .good_out(pkt_good_in),
        .size_out(pkt_size_in), .short_out(pkt_short_in),
        .answer_in({tok_ignore_out, tok_stall_out, tok_accept_out, tx_toggle_out}));
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    always @(negedge core_clk_in) begin
        if (mem_wr_out === 1'b1) begin
            if (n_wr == 0) first_addr = mem_addr_out;
            n_wr++;
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_wr_in    <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string nm);
        @(posedge core_clk_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_rd_in   <= 1'b0;
        #1 check(nm, reg_rdata_out, e);
    endtask : rdchk
    task automatic conclude();
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    // little more than a hundred cycles are expected; the margin is wide
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
    initial begin
        {rst_b_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
        repeat (4) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        rdchk(ADDR_CTRL, RESET_CTRL, "ctrl_reset");
        rdchk(4'hF, 32'h0, "unmapped");
        host_u.token(ans);
        check("ans_disabled", {28'h0, ans}, 32'h8);
        wr(ADDR_CTRL, 32'h4);
        host_u.token(ans);
        check("ans_halt", {28'h0, ans}, 32'h4);
        wr(ADDR_CTRL, 32'h5);
        host_u.token(ans);
        check("ans_armed", {28'h0, ans}, 32'h2);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_COUNT, 32'hC8);
        wr(ADDR_BUF, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        host_u.token(ans);
        host_u.good(10'h040, 1'b0);
        rdchk(ADDR_COUNT, 32'h88, "count_64");
        rdchk(ADDR_BUF, 32'h0001_0000, "offset_64");
        host_u.token(ans);
        host_u.good(10'h00A, 1'b1);
        rdchk(ADDR_COUNT, 32'h7E, "count_short");
        rdchk(ADDR_BUF, 32'h0001_0000, "offset_short");
        rdchk(ADDR_CTRL, 32'h0, "armed_short");
        wr(ADDR_COUNT, 32'h40);
        wr(ADDR_CTRL, 32'h101);
        host_u.token(ans);
        host_u.good(10'h040, 1'b0);
        rdchk(ADDR_COUNT, 32'h0, "count_zero");
        rdchk(ADDR_CTRL, 32'h100, "armed_zero");
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_SKIP, 32'h1);
        rdchk(ADDR_CTRL, 32'h0, "armed_skip");
        wr(ADDR_CTRL, 32'h58);
        rdchk(ADDR_STATUS, 32'h3, "toggle_one");
        wr(ADDR_CTRL, 32'h48);
        rdchk(ADDR_STATUS, 32'h0, "toggle_zero");
        wr(ADDR_BUF, 32'hFFFF_0002);
        wr(ADDR_SETUP, 32'h3);
        wr(ADDR_CTRL, 32'h42);
        n_wr = 0;
        host_u.setup(10);
        repeat (3) @(posedge core_clk_in);
        check("setup_bytes", n_wr, 32'h8);
        check("setup_addr", {10'h0, first_addr}, 32'h140);
        rdchk(ADDR_STATUS, {28'h0, UEPDE_SETUP, 2'b11}, "setup_toggle");
        wr(ADDR_CTRL, 32'h58);
        wr(ADDR_CTRL, 32'h191);
        host_u.token(ans);
        check("ans_feedback", {28'h0, ans}, 32'h2);
        wr(ADDR_COUNT, 32'hC8);
        wr(ADDR_BUF, 32'h0);
        wr(ADDR_CTRL, 32'h21);
        host_u.token(ans);
        host_u.good(10'h0C8, 1'b0);
        rdchk(ADDR_BUF, 32'h0003_0000, "offset_200");
        rdchk(ADDR_STATUS, 32'h3, "iso_toggle");
        rdchk(ADDR_CTRL, 32'h20, "armed_iso");
        conclude();
    end
endmodule : uepde_engine_tb
